// ### pkg/supervisory_timer_pkg.sv
// Constants, register map and field layout of the supervisory timer.
// Assumes an APB master with 32-bit data and byte addresses.
package supervisory_timer_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_LOAD    = 32'hffff0360;
  localparam logic [31:0] ADDR_COUNT   = 32'hffff0364;
  localparam logic [31:0] ADDR_CONTROL = 32'hffff0368;
  localparam logic [31:0] ADDR_CLEAR   = 32'hffff036c;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_LOAD    = 16'h0000;
  localparam logic [15:0] RESET_COUNT   = 16'hffff;
  localparam logic [8:0]  RESET_CONTROL = 9'h000;
  localparam logic [7:0]  RESET_LFSR    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of the control register
  // ----------------------------------------------------------------
  localparam int CTRL_BIT_COUNT_UP = 8;
  localparam int CTRL_BIT_ENABLE   = 7;
  localparam int CTRL_BIT_PERIODIC = 6;
  localparam int CTRL_BIT_WATCHDOG = 5;
  localparam int CTRL_BIT_SECURE   = 4;
  localparam int CTRL_BIT_IRQ_OPT  = 1;
  localparam int CTRL_WIDTH        = 9;

  localparam logic [1:0] PRESCALE_DIV1   = 2'b00;
  localparam logic [1:0] PRESCALE_DIV16  = 2'b01;
  localparam logic [1:0] PRESCALE_DIV256 = 2'b10;

  // Galois taps of x^8 + x^6 + x^5 + x + 1 with the x^8 term implied.
  localparam logic [7:0] LFSR_TAPS = 8'h63;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ      = 100000000;
  localparam int SOURCE_HZ     = 32768;
  localparam int SOURCE_CYCLES = CLOCK_HZ / SOURCE_HZ;

  typedef struct packed {
    logic       count_up;
    logic       enable;
    logic       periodic;
    logic       watchdog;
    logic       secure;
    logic [1:0] prescale;
    logic       irq_opt;
    logic       reserved0;
  } control_t;

endpackage : supervisory_timer_pkg

// ### logic/supervisory_timer.sv
// Supervisory timer: general-purpose 16-bit counter or watchdog with LFSR-checked service.
// Assumes an APB master on pclk and a synchronous reset request consumer downstream.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
module supervisory_timer #(
  parameter int SOURCE_DIV = supervisory_timer_pkg::SOURCE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             timer_irq,
  output logic             watchdog_reset_req
);
  import supervisory_timer_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Galois left shift: zero is a fixed point, so a zero seed can never be matched.
  function automatic logic [7:0] lfsr_next(input logic [7:0] state);
    logic [7:0] shifted;
    logic [7:0] feedback;
    shifted   = {state[6:0], 1'b0};
    feedback  = state[7] ? LFSR_TAPS : 8'h00;
    lfsr_next = shifted ^ feedback;
  endfunction : lfsr_next

  // Code 11 falls to the default and divides by one like code 00.
  function automatic logic prescale_hit(input logic [1:0] sel, input logic [7:0] div);
    unique case (sel)
      PRESCALE_DIV16: begin
        prescale_hit = (div[3:0] == 4'hf);
      end
      PRESCALE_DIV256: begin
        prescale_hit = (div == 8'hff);
      end
      default: begin
        prescale_hit = 1'b1;
      end
    endcase
  endfunction : prescale_hit

  // Every register is one aligned word, decoded on the full byte address.
  function automatic logic addr_is(input logic [31:0] addr, input logic [31:0] reg_addr);
    addr_is = (addr == reg_addr);
  endfunction : addr_is

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        access;
  logic        wr;
  logic        hit_load;
  logic        hit_count;
  logic        hit_control;
  logic        hit_clear;
  logic        mapped;
  logic        locked;
  control_t    control;
  control_t    next_control;
  logic [15:0] load_value;
  logic [15:0] next_load_value;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [7:0]  lfsr;
  logic [7:0]  next_lfsr;
  logic [11:0] src_div;
  logic [7:0]  pre_div;
  logic        src_tick;
  logic        step;
  logic        clear_wr;
  logic        service_match;
  logic        service_ok;
  logic        service_bad;
  logic        at_end;
  logic        next_timer_irq;
  logic        next_reset_req;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Transfers are taken on the access edge only; the setup cycle never changes state.
  always_comb begin
    access = psel && penable;
    wr     = access && pwrite;
  end

  always_comb begin
    hit_load    = addr_is(paddr, ADDR_LOAD);
    hit_count   = addr_is(paddr, ADDR_COUNT);
    hit_control = addr_is(paddr, ADDR_CONTROL);
    hit_clear   = addr_is(paddr, ADDR_CLEAR);
    mapped      = hit_load || hit_count || hit_control || hit_clear;
  end

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  // Zero wait states; unmapped addresses and writes to the count register answer with an error.
  always_comb begin
    pready  = 1'b1;
    pslverr = access && (!mapped || (pwrite && hit_count));
  end

  // Once bit 5 is set only presetn can clear it, so the lock needs no state of its own.
  always_comb begin
    locked   = control.watchdog;
    clear_wr = wr && hit_clear;
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_load) begin
      prdata[15:0] = load_value;
    end else if (hit_count) begin
      prdata[15:0] = count;
    end else if (hit_control) begin
      prdata[CTRL_WIDTH-1:0] = control;
    end
    // The clear register reads as zero so the LFSR never leaks.
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_comb begin
    next_load_value = load_value;
    if (wr && hit_load && !locked) begin
      next_load_value = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_value <= RESET_LOAD;
    end else begin
      load_value <= next_load_value;
    end
  end

  // Only presetn can leave watchdog mode, so the lock also protects bit 5 itself.
  always_comb begin
    next_control = control;
    if (wr && hit_control && !locked) begin
      next_control           = pwdata[CTRL_WIDTH-1:0];
      next_control.reserved0 = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= RESET_CONTROL;
    end else begin
      control <= next_control;
    end
  end

  // ----------------------------------------------------------------
  // 32 kHz source and prescaler
  // ----------------------------------------------------------------
  // The source is derived from pclk, so both modes share one clock domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_div <= 12'h000;
    end else if (src_div == 12'(SOURCE_DIV - 1)) begin
      src_div <= 12'h000;
    end else begin
      src_div <= src_div + 12'h001;
    end
  end

  // The tick is decoded from the divider rather than registered, so it lines up with the wrap.
  always_comb begin
    src_tick = (src_div == 12'(SOURCE_DIV - 1));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_div <= 8'h00;
    end else if (src_tick) begin
      pre_div <= pre_div + 8'h01;
    end
  end

  // Full scale 65535 ticks at 32768/256 Hz is the 512 s ceiling.
  always_comb begin
    step = 1'b0;
    if (src_tick && prescale_hit(control.prescale, pre_div)) begin
      step = control.watchdog || control.enable;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Watchdog mode ignores the direction bit and always counts down.
  always_comb begin
    at_end = (!control.watchdog && control.count_up) ? (count == 16'hffff) : (count == 16'h0000);
  end

  always_comb begin
    next_count = count;
    if (control.watchdog) begin
      if (step && count != 16'h0000) begin
        next_count = count - 16'h0001;
      end
    end else if (step) begin
      if (at_end && control.periodic) begin
        next_count = load_value;
      end else if (control.count_up) begin
        next_count = count + 16'h0001;
      end else begin
        next_count = count - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Service check
  // ----------------------------------------------------------------
  // A zero expected value can never match, so with the secure bit set any service of a zero seed ends in a reset.
  always_comb begin
    service_match = (pwdata[7:0] == lfsr) && (lfsr != 8'h00);
    service_ok    = clear_wr && control.watchdog && (!control.secure || service_match);
    service_bad   = clear_wr && control.watchdog && control.secure && !service_match;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= RESET_COUNT;
    end else if (wr && hit_control && !locked && pwdata[CTRL_BIT_WATCHDOG]) begin
      count <= load_value;
    end else if (wr && hit_load && !locked) begin
      count <= pwdata[15:0];
    end else if (service_ok) begin
      count <= load_value;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // Secure clear sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_lfsr = lfsr;
    if (clear_wr && !control.watchdog) begin
      next_lfsr = pwdata[7:0];
    end else if (service_ok && control.secure) begin
      next_lfsr = lfsr_next(lfsr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= RESET_LFSR;
    end else begin
      lfsr <= next_lfsr;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and reset request
  // ----------------------------------------------------------------
  logic expire_event;

  // ----------------------------------------------------------------
  // Expiry
  // ----------------------------------------------------------------
  // Watchdog expiry is the step that takes the count from one to zero; it stops there.
  always_comb begin
    if (control.watchdog) begin
      expire_event = step && (count == 16'h0001);
    end else begin
      expire_event = step && at_end;
    end
  end

  // Expiry in the same cycle as a clear keeps the interrupt set.
  always_comb begin
    next_timer_irq = timer_irq;
    if (expire_event && (!control.watchdog || control.irq_opt)) begin
      next_timer_irq = 1'b1;
    end else if (clear_wr) begin
      next_timer_irq = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= next_timer_irq;
    end
  end

  // The request stays high until presetn, since it is meant to reset this block too.
  always_comb begin
    next_reset_req = watchdog_reset_req;
    if (service_bad) begin
      next_reset_req = 1'b1;
    end else if (expire_event && control.watchdog && !control.irq_opt) begin
      next_reset_req = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_reset_req <= 1'b0;
    end else begin
      watchdog_reset_req <= next_reset_req;
    end
  end

endmodule : supervisory_timer

// ### sim/supervisory_timer_properties.sv
// Checker for the supervisory timer: bus errors, lock of load and control, watchdog reset.
// Assumes it is bound to supervisory_timer and sees only its ports.
`timescale 1ns/10ps
module supervisory_timer_properties
  import supervisory_timer_pkg::*;
#(
  parameter int SOURCE_DIV = SOURCE_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_irq,
  input wire logic        watchdog_reset_req
);
  // Shadow of what software managed to write; writes after the lock must not count.
  logic        wd;
  logic [8:0]  ctl;
  logic [15:0] ld;
  wire         wr = psel && penable && pwrite;
  wire         rd = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd  <= 1'b0;
      ctl <= 9'h000;
      ld  <= 16'h0000;
    end else if (wr && !wd) begin
      if (paddr == ADDR_CONTROL) begin
        ctl <= {pwdata[8:1], 1'b0};
        wd  <= pwdata[5];
      end
      if (paddr == ADDR_LOAD) ld <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_sticky: assert property (watchdog_reset_req |=> watchdog_reset_req)
    else $error("reset request dropped before reset");
  a_count_ro: assert property (wr && paddr == ADDR_COUNT |-> pslverr)
    else $error("count write not refused");
  a_clear_unread: assert property (rd && paddr == ADDR_CLEAR |-> prdata == 32'h0)
    else $error("clear register read not zero");
  a_zero_seed: assert property (wr && paddr == ADDR_CLEAR && wd && ctl[4] && pwdata[7:0] == 8'h00 |=> watchdog_reset_req)
    else $error("zero service value did not reset");
  a_reset_in_wd: assert property (watchdog_reset_req |-> wd)
    else $error("reset request outside watchdog mode");
  a_irq_option: assert property ($rose(timer_irq) && wd |-> ctl[1])
    else $error("watchdog interrupt without option bit");
  a_load_locked: assert property (rd && paddr == ADDR_LOAD |-> prdata == {16'h0, ld})
    else $error("load register read wrong");
  a_ctrl_locked: assert property (rd && paddr == ADDR_CONTROL |-> prdata == {23'h0, ctl})
    else $error("control register read wrong");
  cover property (wr && paddr == ADDR_CONTROL && pwdata[5]);
  cover property ($rose(watchdog_reset_req));
  cover property ($rose(timer_irq) && wd);
endmodule : supervisory_timer_properties

bind supervisory_timer supervisory_timer_properties #(.SOURCE_DIV(SOURCE_DIV)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq),
  .watchdog_reset_req(watchdog_reset_req));

// ### sim/testbench.sv
// Self-checking bench: registers, prescaled counting, watchdog expiry and secure service.
// Assumes the package and the bound checker are compiled first.
`timescale 1ns/10ps
module testbench;
  import supervisory_timer_pkg::*;
  localparam int SD = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_irq, watchdog_reset_req, err;
  logic [31:0] paddr, pwdata, prdata, rd, ctl;
  logic [7:0]  exp;
  int          n_mismatch, compares, seed, n, dv;

  supervisory_timer #(.SOURCE_DIV(SD)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_irq(timer_irq), .watchdog_reset_req(watchdog_reset_req));

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic guard(input logic ok);
    if (!ok) begin
      n_mismatch++;
      results();
    end
  endtask : guard

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD at %0t got %h want %h", $time, got, want);
    end
  endtask : check

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Sample the answer mid-cycle, where it is settled and holds until the taking edge.
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    guard(n < 50);
    rd      = prdata;
    err     = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [31:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check(rd, want);
  endtask : rdchk

  task automatic wait_flag(input logic which, input int lim);
    n = 0;
    while ((which ? watchdog_reset_req : timer_irq) !== 1'b1 && n < lim) begin
      @(negedge pclk);
      n++;
    end
    guard(n < lim);
  endtask : wait_flag

  task automatic settle;
    @(posedge pclk);
    #1;
  endtask : settle

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // Galois form of x^8+x^6+x^5+x+1, stepped the way software must track it.
  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], 1'b0} ^ (s[7] ? 8'h63 : 8'h00);
  endfunction : step

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h0;
    paddr      = 32'h0;
    pwdata     = 32'h0;
    seed       = 32'h722c;
    n_mismatch = 0;
    compares   = 0;
    do_reset();
    rdchk(ADDR_LOAD, 32'h0);
    rdchk(ADDR_COUNT, 32'hffff);
    rdchk(ADDR_CONTROL, 32'h0);
    rdchk(ADDR_CLEAR, 32'h0);
    apb(1'b1, ADDR_COUNT, 32'h1234);
    check(err, 32'h1);
    repeat (6) begin
      ctl = $random(seed) & 32'hffff_ff5f;
      apb(1'b1, ADDR_CONTROL, ctl);
      rdchk(ADDR_CONTROL, ctl & 32'h1fe);
      apb(1'b1, ADDR_LOAD, ctl);
      rdchk(ADDR_COUNT, ctl & 32'hffff);
    end
    // Four prescale codes counting down, then one run counting up, each three steps to the end.
    for (int k = 0; k < 5; k++) begin
      ctl = (k == 4) ? 32'h180 : 32'h80 | (k << 2);
      dv  = (k == 1) ? 16 : (k == 2) ? 256 : 1;
      do_reset();
      apb(1'b1, ADDR_LOAD, (k == 4) ? 32'hfffd : 32'h2);
      apb(1'b1, ADDR_CONTROL, ctl);
      wait_flag(1'b0, 4000);
      check(n >= (2 * dv - 1) * SD && n <= (3 * dv + 1) * SD + 8, 32'h1);
      apb(1'b1, ADDR_CLEAR, $random(seed));
      settle();
      check(timer_irq, 32'h0);
    end
    do_reset();
    apb(1'b1, ADDR_LOAD, 32'h5);
    apb(1'b1, ADDR_CONTROL, 32'h22);
    apb(1'b1, ADDR_CONTROL, 32'h0);
    apb(1'b1, ADDR_LOAD, 32'h7);
    rdchk(ADDR_CONTROL, 32'h22);
    rdchk(ADDR_LOAD, 32'h5);
    wait_flag(1'b0, 200);
    check(watchdog_reset_req, 32'h0);
    rdchk(ADDR_COUNT, 32'h0);
    do_reset();
    apb(1'b1, ADDR_LOAD, 32'h8);
    apb(1'b1, ADDR_CONTROL, 32'h20);
    repeat (12) begin
      repeat (2 * SD) @(posedge pclk);
      apb(1'b1, ADDR_CLEAR, $random(seed));
    end
    check(watchdog_reset_req, 32'h0);
    wait_flag(1'b1, 200);
    check(n >= 7 * SD - 2, 32'h1);
    // Fixed seed with a wrong fourth value, a random seed, and the forbidden zero seed.
    for (int k = 0; k < 3; k++) begin
      do_reset();
      exp = $random(seed);
      exp = (k == 0) ? 8'haa : (k == 1) ? (exp | 8'h01) : 8'h00;
      apb(1'b1, ADDR_CLEAR, {24'h0, exp});
      apb(1'b1, ADDR_LOAD, 32'h100);
      apb(1'b1, ADDR_CONTROL, 32'h30);
      repeat ((k == 2) ? 0 : 3 + 2 * k) begin
        apb(1'b1, ADDR_CLEAR, {24'h0, exp});
        exp = step(exp);
      end
      settle();
      check(watchdog_reset_req, 32'h0);
      if (k == 0) check(exp, 32'hdc);
      apb(1'b1, ADDR_CLEAR, {24'h0, (k == 0) ? 8'h66 : (k == 1) ? exp ^ 8'h5a : exp});
      settle();
      check(watchdog_reset_req, 32'h1);
    end
    results();
  end
endmodule : testbench
